// ---- include/umm_defines.vh ----
/*
 * Constants of the unified memory map decoder: own register offsets,
 * reset values, address windows, target codes and address modes.
 * Assumes inclusion by plain name from design files of this block.
 */
`ifndef UMM_DEFINES_VH
`define UMM_DEFINES_VH

`define UMM_DP0_LOW_OFS   8'h82
`define UMM_DP0_HIGH_OFS  8'h83
`define UMM_DP1_LOW_OFS   8'h84
`define UMM_DP1_HIGH_OFS  8'h85
`define UMM_PTR_SEL_OFS   8'h92
`define UMM_PAGE_HIGH_OFS 8'h93
`define UMM_REG_RST       8'h00
`define UMM_PTR_SEL_BIT   0

`define UMM_FLASH_LAST    16'h7fff
`define UMM_RF_FIRST      16'hdf00
`define UMM_RF_LAST       16'hdf3d
`define UMM_SFR_FIRST     16'hdf80
`define UMM_SRAM_FIRST    16'hf000
`define UMM_DATA_PAGE     8'hff

`define UMM_T_NONE        3'd0
`define UMM_T_FLASH       3'd1
`define UMM_T_SRAM        3'd2
`define UMM_T_RF          3'd3
`define UMM_T_SFR         3'd4

`define UMM_XM_ADDR       2'd0
`define UMM_XM_DPTR       2'd1
`define UMM_XM_PAGE       2'd2

`endif

// ---- hw/umm_decoder.v ----
/*
 * Unified memory map decoder: one shared memory bus for CPU external
 * data moves, DMA, direct data and code fetches, with the on-chip SRAM,
 * the two data pointers, the pointer select and the page register.
 * Assumes all requesters, flash, radio and peripheral register files
 * run on clk; read data of flash, radio and peripheral files is valid
 * in the same cycle as their strobe.
 */
`timescale 1ns/1ps
`include "umm_defines.vh"

// Operation
// - External-data addresses 0x0000-0x7FFF reach the 32 KB flash.
// - External-data addresses 0xF000-0xFFFF reach the 4 KB SRAM.
// - External-data addresses 0xDF00-0xDF3D reach the radio registers.
// - SRAM contents are kept through the deep low-power modes.
// - Code space decodes like external data, never reaching CPU SFRs.
// - Instruction fetches from the SRAM window are served.
// - Fetches and external-data moves share one bus, never together.
// - Direct-data space is the top 256 SRAM bytes, also at 0xFF00.
// - The SFR space is mirrored into external data at 0xDF80-0xDFFF and repeats every 128 bytes up to 0xEFFF.
// - CPU-internal SFRs are reachable only by direct SFR access.
// - Two 16-bit data pointers, each of a high and a low byte register.
// - Pointer select bit 0 picks the first (0) or second (1) pointer.
// - Register-indirect moves use page register high, Ri low.
// - Pointers, select and page reset to zero; select bits 7:1 read 0.
// - SFRs at multiples of eight are also bit addressable.
module umm_decoder #(
    parameter [127:0] CPU_SFR_MASK =
        128'h0001_0101_0001_0001_0300_0300_0d0c_01be
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        pwr_deep,
    input  wire [7:0]  sfr_addr,
    input  wire        sfr_bit,
    input  wire        sfr_wr,
    input  wire [7:0]  sfr_wdata,
    output reg  [7:0]  sfr_rdata_q,
    input  wire        x_req,
    input  wire        x_we,
    input  wire [1:0]  x_mode,
    input  wire [15:0] x_addr,
    input  wire [7:0]  x_ri,
    input  wire [7:0]  x_wdata,
    output wire        x_ack,
    input  wire        dma_req,
    input  wire        dma_we,
    input  wire [15:0] dma_addr,
    input  wire [7:0]  dma_wdata,
    output wire        dma_ack,
    input  wire        data_req,
    input  wire        data_we,
    input  wire [7:0]  data_addr,
    input  wire [7:0]  data_wdata,
    output wire        data_ack,
    input  wire        fetch_req,
    input  wire        fetch_dptr,
    input  wire [15:0] fetch_addr,
    input  wire [7:0]  fetch_off,
    output wire        fetch_ack,
    output reg  [7:0]  mem_rdata_q,
    output reg  [14:0] flash_addr_q,
    output reg         flash_rd_q,
    input  wire [7:0]  flash_rdata,
    output reg  [5:0]  rf_addr_q,
    output reg         rf_rd_q,
    output reg         rf_we_q,
    input  wire [7:0]  rf_rdata,
    output reg  [6:0]  psfr_addr_q,
    output reg         psfr_rd_q,
    output reg         psfr_we_q,
    input  wire [7:0]  psfr_rdata,
    output reg  [7:0]  bus_wdata_q
);

    reg  [7:0]  dp0_low_q;
    reg  [7:0]  dp0_high_q;
    reg  [7:0]  dp1_low_q;
    reg  [7:0]  dp1_high_q;
    reg         ptr_sel_q;
    reg  [7:0]  page_high_q;
    reg  [3:0]  pend_q;
    reg  [3:0]  ack_q;
    reg  [3:0]  a_oh_q;
    reg  [2:0]  a_tgt_q;
    reg  [7:0]  sram_q;
    reg  [7:0]  sram [0:4095];

    reg  [15:0] dptr_sel;
    reg  [15:0] x_eff;
    reg  [15:0] f_eff;
    reg  [3:0]  req_v;
    reg  [3:0]  elig;
    reg  [3:0]  gnt;
    reg  [3:0]  lower;
    reg  [15:0] wa;
    reg         wwe;
    reg  [7:0]  wwd;
    reg  [2:0]  tgt;
    reg  [7:0]  sfr_ba;
    reg  [7:0]  sfr_cur;
    reg  [7:0]  sfr_new;
    integer     i;

    assign x_ack     = ack_q[0];
    assign dma_ack   = ack_q[1];
    assign data_ack  = ack_q[2];
    assign fetch_ack = ack_q[3];

    // Address of a CPU or DMA access into the unified map
    function [2:0] umm_decode;
        input [15:0] a;
        begin
            if (a <= `UMM_FLASH_LAST)
                umm_decode = `UMM_T_FLASH;
            else if (a >= `UMM_SRAM_FIRST)
                umm_decode = `UMM_T_SRAM;
            else if (a >= `UMM_RF_FIRST && a <= `UMM_RF_LAST)
                umm_decode = `UMM_T_RF;
            else if (a >= `UMM_SFR_FIRST && a < `UMM_SRAM_FIRST &&
                     !CPU_SFR_MASK[a[6:0]])
                umm_decode = `UMM_T_SFR;
            else
                umm_decode = `UMM_T_NONE;
        end
    endfunction

    always @* begin
        dptr_sel = ptr_sel_q ? {dp1_high_q, dp1_low_q}
                             : {dp0_high_q, dp0_low_q};
        case (x_mode)
            `UMM_XM_DPTR: x_eff = dptr_sel;
            `UMM_XM_PAGE: x_eff = {page_high_q, x_ri};
            default:      x_eff = x_addr;
        endcase
        f_eff = fetch_dptr ? dptr_sel + {8'h00, fetch_off} : fetch_addr;
    end

    // Fixed priority on the one shared bus; a fetch waits for data moves
    always @* begin
        req_v = {fetch_req, data_req, dma_req, x_req};
        elig  = pwr_deep ? 4'h0 : (req_v & ~pend_q & ~ack_q);
        lower = 4'h0;
        gnt   = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            gnt[i] = elig[i] & ~|(elig & lower);
            lower[i] = 1'b1;
        end
    end

    always @* begin
        wa  = 16'h0000;
        wwe = 1'b0;
        wwd = 8'h00;
        case (gnt)
            4'b0001: begin
                wa  = x_eff;
                wwe = x_we;
                wwd = x_wdata;
            end
            4'b0010: begin
                wa  = dma_addr;
                wwe = dma_we;
                wwd = dma_wdata;
            end
            4'b0100: begin
                wa  = {`UMM_DATA_PAGE, data_addr};
                wwe = data_we;
                wwd = data_wdata;
            end
            4'b1000: begin
                wa  = f_eff;
            end
            default: begin
                wa  = 16'h0000;
            end
        endcase
        tgt = (|gnt) ? umm_decode(wa) : `UMM_T_NONE;
    end

    // SRAM has no reset and no clear, so it holds across sleep
    always @(posedge clk) begin
        if (tgt == `UMM_T_SRAM) begin
            if (wwe)
                sram[wa[11:0]] <= wwd;
            sram_q <= sram[wa[11:0]];
        end
    end

    // Stage one: grant and strobes; stage two: answer and read data
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q       <= 4'h0;
            ack_q        <= 4'h0;
            a_oh_q       <= 4'h0;
            a_tgt_q      <= `UMM_T_NONE;
            flash_addr_q <= 15'h0000;
            flash_rd_q   <= 1'b0;
            rf_addr_q    <= 6'h00;
            rf_rd_q      <= 1'b0;
            rf_we_q      <= 1'b0;
            psfr_addr_q  <= 7'h00;
            psfr_rd_q    <= 1'b0;
            psfr_we_q    <= 1'b0;
            bus_wdata_q  <= 8'h00;
            mem_rdata_q  <= 8'h00;
        end else begin
            pend_q      <= (pend_q | gnt) & ~a_oh_q;
            ack_q       <= a_oh_q;
            a_oh_q      <= gnt;
            a_tgt_q     <= tgt;
            flash_addr_q <= wa[14:0];
            flash_rd_q  <= (tgt == `UMM_T_FLASH) & ~wwe;
            rf_addr_q   <= wa[5:0];
            rf_rd_q     <= (tgt == `UMM_T_RF) & ~wwe;
            rf_we_q     <= (tgt == `UMM_T_RF) & wwe;
            psfr_addr_q <= wa[6:0];
            psfr_rd_q   <= (tgt == `UMM_T_SFR) & ~wwe;
            psfr_we_q   <= (tgt == `UMM_T_SFR) & wwe;
            bus_wdata_q <= wwd;
            case (a_tgt_q)
                `UMM_T_FLASH: mem_rdata_q <= flash_rdata;
                `UMM_T_SRAM:  mem_rdata_q <= sram_q;
                `UMM_T_RF:    mem_rdata_q <= rf_rdata;
                `UMM_T_SFR:   mem_rdata_q <= psfr_rdata;
                default:      mem_rdata_q <= 8'h00;
            endcase
        end
    end

    // Direct SFR port; a bit access works on the byte at addr & 0xf8
    always @* begin
        sfr_ba = sfr_bit ? {sfr_addr[7:3], 3'b000} : sfr_addr;
        case (sfr_ba)
            `UMM_DP0_LOW_OFS:   sfr_cur = dp0_low_q;
            `UMM_DP0_HIGH_OFS:  sfr_cur = dp0_high_q;
            `UMM_DP1_LOW_OFS:   sfr_cur = dp1_low_q;
            `UMM_DP1_HIGH_OFS:  sfr_cur = dp1_high_q;
            `UMM_PTR_SEL_OFS:   sfr_cur = {7'h00, ptr_sel_q};
            `UMM_PAGE_HIGH_OFS: sfr_cur = page_high_q;
            default:            sfr_cur = 8'h00;
        endcase
        sfr_new = sfr_wdata;
        if (sfr_bit)
            sfr_new = (sfr_cur & ~(8'h01 << sfr_addr[2:0])) |
                      ({7'h00, sfr_wdata[0]} << sfr_addr[2:0]);
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dp0_low_q   <= `UMM_REG_RST;
            dp0_high_q  <= `UMM_REG_RST;
            dp1_low_q   <= `UMM_REG_RST;
            dp1_high_q  <= `UMM_REG_RST;
            ptr_sel_q   <= 1'b0;
            page_high_q <= `UMM_REG_RST;
            sfr_rdata_q <= 8'h00;
        end else begin
            if (sfr_bit)
                sfr_rdata_q <= {7'h00, sfr_cur[sfr_addr[2:0]]};
            else
                sfr_rdata_q <= sfr_cur;
            if (sfr_wr) begin
                case (sfr_ba)
                    `UMM_DP0_LOW_OFS:   dp0_low_q  <= sfr_new;
                    `UMM_DP0_HIGH_OFS:  dp0_high_q <= sfr_new;
                    `UMM_DP1_LOW_OFS:   dp1_low_q  <= sfr_new;
                    `UMM_DP1_HIGH_OFS:  dp1_high_q <= sfr_new;
                    `UMM_PTR_SEL_OFS:
                        ptr_sel_q <= sfr_new[`UMM_PTR_SEL_BIT];
                    `UMM_PAGE_HIGH_OFS: page_high_q <= sfr_new;
                    default: begin
                        page_high_q <= page_high_q;
                    end
                endcase
            end
        end
    end

endmodule // umm_decoder

// ---- verification/umm_far_model.sv ----
/* Far-side read model for flash, radio and peripheral register files.
   Assumes strobe and address are flops of the decoder on clk. */
`timescale 1ns/1ps
module umm_far_model #(
    parameter int         AW  = 15,
    parameter logic [7:0] KEY = 8'h5a
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] addr,
    input  wire logic          rd,
    output logic [7:0]         rdata
);
    wire  [AW+7:0] ext = {8'h00, addr};
    logic [7:0]    hold_q = 8'h00;
    logic [7:0]    last_q = 8'h00;
    logic          was_q  = 1'b0;
    always @(posedge clk) begin
        was_q <= rd;
        if (rd) hold_q <= ext[7:0] ^ KEY;
        last_q <= rdata;
    end
    // For one cycle after the read window the byte holds, then it toggles so stale data matches only every other cycle
    assign rdata = rd ? ext[7:0] ^ KEY : was_q ? hold_q : ~last_q;
endmodule // umm_far_model

// ---- verification/umm_decoder_props.sv ----
/* Port assertions of the memory map decoder.
   Assumes binding into umm_decoder, whose ports it watches. */
`timescale 1ns/1ps
`include "umm_defines.vh"
module umm_decoder_props #(
    parameter [127:0] CPU_SFR_MASK = 128'h0
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       pwr_deep,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_bit,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata_q,
    input wire logic       x_req,
    input wire logic       x_ack,
    input wire logic       dma_ack,
    input wire logic       data_ack,
    input wire logic       fetch_ack,
    input wire logic       flash_rd_q,
    input wire logic [5:0] rf_addr_q,
    input wire logic       rf_rd_q,
    input wire logic       rf_we_q,
    input wire logic [6:0] psfr_addr_q,
    input wire logic       psfr_rd_q,
    input wire logic       psfr_we_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire [3:0] ak = {fetch_ack, data_ack, dma_ack, x_ack};
    sequence s_strobe;
        flash_rd_q || rf_rd_q || rf_we_q || psfr_rd_q || psfr_we_q;
    endsequence
    sequence s_lo_wr;
        sfr_wr && !sfr_bit && sfr_addr == `UMM_DP0_LOW_OFS;
    endsequence
    sequence s_lo_rd;
        !sfr_wr && !sfr_bit && sfr_addr == `UMM_DP0_LOW_OFS;
    endsequence
    AST_ONE_BUS: assert property ($onehot0(ak))
        else $error("two acks in one cycle");
    AST_X_LAT: assert property ($rose(x_req) && !pwr_deep |-> ##2 x_ack)
        else $error("cpu move not answered in two cycles");
    AST_X_PULSE: assert property (x_ack |=> !x_ack)
        else $error("ack longer than one cycle");
    AST_STROBE_ACK: assert property (s_strobe |=> x_ack || dma_ack || fetch_ack)
        else $error("strobe without answer");
    AST_RF_WIN: assert property (rf_rd_q || rf_we_q |-> rf_addr_q <= 6'h3d)
        else $error("radio strobe outside window");
    AST_CPU_HIDDEN: assert property (psfr_rd_q || psfr_we_q |-> !CPU_SFR_MASK[psfr_addr_q])
        else $error("cpu register reached through mirror");
    AST_DEEP_IDLE: assert property (pwr_deep |-> ##2 ak == 4'h0)
        else $error("grant in deep mode");
    AST_SEL_ZERO: assert property (!sfr_bit && sfr_addr == `UMM_PTR_SEL_OFS |=> sfr_rdata_q[7:1] == 7'h00)
        else $error("select upper bits not zero");
    AST_PTR_KEEP: assert property (s_lo_wr ##1 s_lo_rd |=> sfr_rdata_q == $past(sfr_wdata, 2))
        else $error("pointer byte lost");
endmodule // umm_decoder_props
bind umm_decoder umm_decoder_props #(.CPU_SFR_MASK(CPU_SFR_MASK)) umm_decoder_props_i (.*);

// ---- verification/tb_umm_decoder.sv ----
/* Self-checking bench of the memory map decoder with far-side models.
   Assumes umm_decoder, umm_far_model and the checker are compiled. */
`timescale 1ns/1ps
`include "umm_defines.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_umm_decoder;
    logic        clk = 0, rst_b = 0, pwr_deep = 0, sfr_bit = 0, sfr_wr = 0;
    logic        x_req = 0, x_we = 0, dma_req = 0, dma_we = 0, look = 0;
    logic        data_req = 0, data_we = 0, fetch_req = 0, fetch_dptr = 0;
    logic [1:0]  x_mode = 0;
    logic [7:0]  sfr_addr = 0, sfr_wdata = 0, x_ri = 0, x_wdata = 0, v, w, e;
    logic [7:0]  dma_wdata = 0, data_addr = 0, data_wdata = 0, fetch_off = 0;
    logic [15:0] x_addr = 0, dma_addr = 0, fetch_addr = 0;
    wire  [7:0]  sfr_rdata_q, mem_rdata_q, flash_rdata, rf_rdata, psfr_rdata;
    wire  [7:0]  bus_wdata_q;
    wire  [14:0] flash_addr_q;
    wire  [5:0]  rf_addr_q;
    wire  [6:0]  psfr_addr_q;
    wire         x_ack, dma_ack, data_ack, fetch_ack, flash_rd_q, rf_rd_q;
    wire         rf_we_q, psfr_rd_q, psfr_we_q;
    wire  [3:0]  ak = {fetch_ack, data_ack, dma_ack, x_ack};
    logic [31:0] lf = 32'h4fc2ea7b;
    logic [8:0]  qm[4][$];
    logic [8:0]  m;
    logic [7:0]  qs[$];
    logic [7:0]  ro[6] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'h93};
    logic [15:0] ta[6] = '{16'h7fff, 16'h8000, 16'hdf3d, 16'hdf3e,
                           16'hdf80, 16'hdf82};
    logic [7:0]  te[6] = '{8'ha5, 8'h00, 8'hfe, 8'h00, 8'h96, 8'h00};
    int          fails = 0, checks = 0, i;
    int          nwe = 0;
    logic [7:0]  wd = 0;
    always #50 clk = ~clk;
    umm_decoder umm_decoder_i (.*);
    umm_far_model #(.KEY(8'h5a)) umm_far_model_i0 (.clk(clk),
        .addr(flash_addr_q), .rd(flash_rd_q), .rdata(flash_rdata));
    umm_far_model #(.AW(6), .KEY(8'hc3)) umm_far_model_i1 (.clk(clk),
        .addr(rf_addr_q), .rd(rf_rd_q), .rdata(rf_rdata));
    umm_far_model #(.AW(7), .KEY(8'h96)) umm_far_model_i2 (.clk(clk),
        .addr(psfr_addr_q), .rd(psfr_rd_q), .rdata(psfr_rdata));
    function automatic logic [7:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction
    task automatic sw(input logic [7:0] a, d, input logic b = 1'b0);
        @(negedge clk);
        {sfr_addr, sfr_wdata, sfr_wr, sfr_bit} = {a, d, 1'b1, b};
        @(negedge clk);
        {sfr_wr, sfr_bit} = 2'b00;
    endtask
    task automatic sr(input logic [7:0] a, x, input logic b = 1'b0);
        @(negedge clk);
        {sfr_addr, sfr_bit} = {a, b};
        qs.push_back(x);
        @(posedge clk);
        look = 1;
    endtask
    // Source 0 cpu move, 1 dma, 2 direct data, 3 code fetch
    task automatic acc(input int s, input logic we,
                       input logic [15:0] a, input logic [7:0] d, x);
        int n;
        @(negedge clk);
        qm[s].push_back({!we, x});
        wd = d;
        case (s)
            0: {x_we, x_addr, x_ri, x_wdata, x_req} = {we, a, a[7:0], d, 1'b1};
            1: {dma_we, dma_addr, dma_wdata, dma_req} = {we, a, d, 1'b1};
            2: {data_we, data_addr, data_wdata, data_req} = {we, a[7:0], d, 1'b1};
            default: {fetch_addr, fetch_off, fetch_req} = {a, a[7:0], 1'b1};
        endcase
        n = 0;
        do begin @(negedge clk); n++; end while (ak[s] !== 1'b1 && n < 50);
        `CHK(ak[s], 1'b1)
        x_req &= s != 0;
        dma_req &= s != 1;
        data_req &= s != 2;
        fetch_req &= s != 3;
    endtask
    task close_out;
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(negedge clk) begin
        if (rf_we_q | psfr_we_q) begin
            nwe++;
            `CHK(bus_wdata_q, wd)
        end
        if (rf_we_q) `CHK(rf_addr_q, 6'h3d)
        if (psfr_we_q) `CHK(psfr_addr_q, 7'h00)
        for (int k = 0; k < 4; k++)
            if (ak[k] === 1'b1 && qm[k].size() > 0) begin
                m = qm[k].pop_front();
                if (m[8]) `CHK(mem_rdata_q, m[7:0])
            end
        if (look) begin
            look = 0;
            e = qs.pop_front();
            `CHK(sfr_rdata_q, e)
        end
    end
    initial begin
        #1000000;
        fails++;
        close_out;
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst_b = 1;
        for (i = 0; i < 6; i++) sr(ro[i], 8'h00);
        for (i = 0; i < 6; i++) begin
            v = rnd();
            sw(ro[i], v);
            sr(ro[i], i == 4 ? {7'h00, v[0]} : v);
        end
        v = rnd();
        w = rnd();
        acc(0, 1, 16'hf010, v, 0);
        acc(1, 1, 16'hf00f, w, 0);
        acc(3, 0, 16'hf010, 0, v);
        acc(1, 1, 16'hffa5, w, 0);
        acc(2, 0, 16'h00a5, 0, w);
        acc(2, 1, 16'h0033, v, 0);
        acc(0, 0, 16'hff33, 0, v);
        for (i = 0; i < 6; i++) acc(0, 1, ta[i], rnd(), 0);
        `CHK(nwe, 2)
        for (i = 0; i < 18; i++)
            acc(i % 3 == 2 ? 3 : i % 3, 0, ta[i / 3], 0,
                te[i / 3]);
        sw(8'h82, 8'h0f);
        sw(8'h83, 8'hf0);
        sw(8'h84, 8'h10);
        sw(8'h85, 8'hf0);
        sw(8'h82, 8'h00, 1'b1);
        sr(8'h82, 8'h0f);
        sr(8'h84, 8'h00, 1'b1);
        sw(8'h92, 8'h01);
        x_mode = `UMM_XM_DPTR;
        acc(0, 0, 16'h0000, 0, v);
        sw(8'h92, 8'h00);
        acc(0, 0, 16'h0000, 0, w);
        sw(8'h93, 8'hf0);
        x_mode = `UMM_XM_PAGE;
        acc(0, 0, 16'h000f, 0, w);
        x_mode = `UMM_XM_ADDR;
        fetch_dptr = 1;
        acc(3, 0, 16'h0001, 0, v);
        fetch_dptr = 0;
        fork
            acc(0, 0, 16'hf010, 0, v);
            acc(1, 0, 16'hf00f, 0, w);
            acc(2, 0, 16'h00a5, 0, w);
            acc(3, 0, 16'h7fff, 0, 8'ha5);
        join
        @(negedge clk) rst_b = 0;
        @(negedge clk) rst_b = 1;
        for (i = 0; i < 6; i++) sr(ro[i], 8'h00);
        @(negedge clk);
        pwr_deep = 1;
        fork
            acc(0, 0, 16'hf010, 0, v);
            begin repeat (8) @(negedge clk); pwr_deep = 0; end
        join
        close_out;
    end
endmodule // tb_umm_decoder
